/* File: hw/usb_ep_pkg.sv */
// usb_ep_pkg: register indices, field positions, reset state and carriers of the
// endpoint/pipe status block. assumes a 32-bit avalon-mm slave, byte addressing.
package usb_ep_pkg;
  // register word indices; byte address is four times the index
  localparam logic [9:0] IDX_CONFIG     = 10'h000;
  localparam logic [9:0] IDX_STATUS_CLR = 10'h004;
  localparam logic [9:0] IDX_STATUS_SET = 10'h005;
  localparam logic [9:0] IDX_STATUS     = 10'h006;
  localparam logic [9:0] IDX_BANK_STAT  = 10'h007;
  localparam logic [9:0] IDX_IRQEN_CLR  = 10'h008;
  localparam logic [9:0] IDX_IRQEN_SET  = 10'h009;
  localparam logic [9:0] IDX_PIPE_CTRL  = 10'h00C;
  localparam logic [9:0] IDX_INT_FLAGS  = 10'h107;
  // config bits
  localparam int CFG_HOST_MODE  = 0;
  localparam int CFG_PIPE_EN    = 1;
  localparam int CFG_SOFT_RESET = 7;
  // status bits
  localparam int ST_BANK0_READY = 6;
  localparam int ST_STALL_REQ   = 4;
  localparam int ST_PIPE_FREEZE = 4;
  localparam int ST_CUR_BANK    = 2;
  localparam int ST_IN_TOGGLE   = 1;
  localparam int ST_OUT_TOGGLE  = 0;
  localparam int ST_PIPE_TOGGLE = 0;
  localparam logic [7:0] ST_DEV_MASK  = 8'h57;
  localparam logic [7:0] ST_HOST_MASK = 8'h15;
  // interrupt flag bits
  localparam int FL_STALL      = 5;
  localparam int FL_SETUP_SENT = 4;
  localparam int FL_PIPE_ERR   = 3;
  localparam int FL_XFER_FAIL  = 2;
  localparam int FL_XFER_DONE  = 0;
  localparam logic [7:0] FL_MASK = 8'h3D;
  // bank status bits
  localparam int BK_FLOW_ERR = 1;
  localparam int BK_CRC_ERR  = 0;
  // host pipe control fields
  localparam int PC_LIMIT_LSB = 12;
  localparam int PC_EPNUM_LSB = 8;
  localparam logic [15:0] PC_MASK = 16'hFF7F;

  // events from the packet engine, same clock, one-cycle pulses except trans_active
  typedef struct packed {
    logic setup_rcvd;
    logic bank_filled;
    logic bank_released;
    logic in_done;
    logic out_done;
    logic trans_active;
    logic trans_done;
    logic stall_rcvd;
    logic lpm_done;
    logic pipe_err;
    logic nak_rcvd;
    logic iso_overrun;
    logic iso_underflow;
    logic crc_err;
    logic xfer_done;
    logic xfer_fail;
    logic setup_sent;
  } usb_evt_s;

  // controls toward the packet engine
  typedef struct packed {
    logic       stall_handshake;
    logic       current_bank;
    logic       in_toggle;
    logic       out_toggle;
    logic       pipe_toggle;
    logic       pipe_frozen;
    logic       req_allowed;
    logic [3:0] endpoint_num;
    logic [6:0] device_addr;
    logic       irq_request;
  } usb_ctl_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        host_mode;
    logic        pipe_en;
    logic [7:0]  status;
    logic        freeze_pend;
    logic        freeze;
    logic        pipe_tgl;
    logic [3:0]  err_cnt;
    logic [7:0]  flags;
    logic [7:0]  irq_en;
    logic [1:0]  bank_st;
    logic [15:0] pctrl;
  } state_s;

  localparam state_s ST_RESET = '0;
endpackage

/* File: hw/usb_ep_status.sv */
// usb_ep_status: endpoint and pipe status/control registers of a full-speed usb
// controller. assumes a packet engine on core_clk driving usb_evt_s pulses.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
module usb_ep_status
  import usb_ep_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire usb_evt_s    evt,
  output usb_ctl_s         ctl
);

  state_s     st_ff;
  state_s     nxt_st;
  logic [9:0] idx;
  logic       req;
  logic       wr;
  logic [7:0] st_clr;
  logic [7:0] st_set;
  logic [7:0] st_msk;
  logic [7:0] fl_clr;
  logic [7:0] fl_set;
  logic [7:0] ie_clr;
  logic [7:0] ie_set;
  logic [1:0] bk_clr;
  logic [3:0] limit;
  logic [3:0] cnt_inc;
  logic       en_rise;

  assign idx = avs_address[11:2];
  assign req = avs_read | avs_write;
  // one wait state: the first cycle of a request decodes, the second answers
  assign avs_waitrequest = req & ~st_ff.ack;
  assign avs_readdata    = st_ff.rdata;
  assign wr = avs_write & st_ff.ack & avs_byteenable[0];
  assign limit = st_ff.pctrl[PC_LIMIT_LSB +: 4];

  // write strobes per register; masks keep reserved bits from ever storing
  always_comb begin
    st_msk = st_ff.host_mode ? ST_HOST_MASK : ST_DEV_MASK;
    st_clr = (wr && idx == IDX_STATUS_CLR) ? (avs_writedata[7:0] & st_msk) : 8'h00;
    st_set = (wr && idx == IDX_STATUS_SET) ? (avs_writedata[7:0] & st_msk) : 8'h00;
    fl_clr = (wr && idx == IDX_INT_FLAGS) ? (avs_writedata[7:0] & FL_MASK) : 8'h00;
    ie_clr = (wr && idx == IDX_IRQEN_CLR) ? (avs_writedata[7:0] & FL_MASK) : 8'h00;
    ie_set = (wr && idx == IDX_IRQEN_SET) ? (avs_writedata[7:0] & FL_MASK) : 8'h00;
    bk_clr = (wr && idx == IDX_BANK_STAT) ? avs_writedata[1:0] : 2'h0;
  end

  // all state updates in one place
  always_comb begin
    nxt_st  = st_ff;
    cnt_inc = st_ff.err_cnt + 4'h1;
    en_rise = 1'b0;
    nxt_st.ack = req & ~st_ff.ack;

    // read mux, captured in the decode cycle so readdata comes from a flop
    if (req & ~st_ff.ack) begin
      unique case (idx)
        IDX_CONFIG:
          nxt_st.rdata = {30'h0, st_ff.pipe_en, st_ff.host_mode};
        IDX_STATUS_CLR, IDX_STATUS_SET, IDX_STATUS:
          if (st_ff.host_mode)
            nxt_st.rdata = {27'h0, st_ff.freeze, 1'b0, st_ff.status[ST_CUR_BANK], 1'b0, st_ff.pipe_tgl};
          else
            nxt_st.rdata = {24'h0, st_ff.status};
        IDX_BANK_STAT:
          nxt_st.rdata = {30'h0, st_ff.bank_st};
        IDX_IRQEN_CLR, IDX_IRQEN_SET:
          nxt_st.rdata = {24'h0, st_ff.irq_en};
        IDX_PIPE_CTRL:
          nxt_st.rdata = {16'h0, st_ff.pctrl};
        IDX_INT_FLAGS:
          nxt_st.rdata = {24'h0, st_ff.flags};
        default:
          nxt_st.rdata = 32'h0;
      endcase
    end

    // configuration; pipe enable rising edge is itself an interrupt event
    if (wr && idx == IDX_CONFIG) begin
      nxt_st.host_mode = avs_writedata[CFG_HOST_MODE];
      nxt_st.pipe_en   = avs_writedata[CFG_PIPE_EN];
      en_rise          = avs_writedata[CFG_PIPE_EN] & ~st_ff.pipe_en;
    end
    if (wr && idx == IDX_PIPE_CTRL) begin
      nxt_st.pctrl[7:0] = avs_writedata[7:0] & PC_MASK[7:0];
      if (avs_byteenable[1])
        nxt_st.pctrl[15:8] = avs_writedata[15:8];
    end

    // device endpoint: hardware effects first, software set/clear after
    if (!st_ff.host_mode) begin
      if (evt.setup_rcvd)
        nxt_st.status[ST_STALL_REQ] = 1'b0;
      if (evt.bank_released)
        nxt_st.status[ST_BANK0_READY] = 1'b0;
      if (evt.bank_filled)
        nxt_st.status[ST_BANK0_READY] = 1'b1;
      if (evt.in_done)
        nxt_st.status[ST_IN_TOGGLE] = ~st_ff.status[ST_IN_TOGGLE];
      if (evt.out_done)
        nxt_st.status[ST_OUT_TOGGLE] = ~st_ff.status[ST_OUT_TOGGLE];
      // clear takes precedence over a simultaneous set
      nxt_st.status = (nxt_st.status & ~st_clr) | (st_set & ~st_clr);
    end else begin
      nxt_st.status[ST_CUR_BANK] = (st_ff.status[ST_CUR_BANK] & ~st_clr[ST_CUR_BANK])
                                 | (st_set[ST_CUR_BANK] & ~st_clr[ST_CUR_BANK]);
      if (evt.trans_done)
        nxt_st.pipe_tgl = ~st_ff.pipe_tgl;
      if (st_clr[ST_PIPE_TOGGLE])
        nxt_st.pipe_tgl = 1'b0;
      else if (st_set[ST_PIPE_TOGGLE])
        nxt_st.pipe_tgl = 1'b1;
      // errors count up; at the limit the pipe freezes like a software freeze
      if (evt.pipe_err) begin
        nxt_st.err_cnt = (st_ff.err_cnt == 4'hF) ? st_ff.err_cnt : cnt_inc;
        if (limit != 4'h0 && cnt_inc >= limit)
          nxt_st.freeze_pend = 1'b1;
      end
      if (st_set[ST_PIPE_FREEZE])
        nxt_st.freeze_pend = 1'b1;
      // a pending freeze only lands once the bus is idle
      if (nxt_st.freeze_pend && !evt.trans_active) begin
        nxt_st.freeze      = 1'b1;
        nxt_st.freeze_pend = 1'b0;
      end
      if (st_clr[ST_PIPE_FREEZE]) begin
        nxt_st.freeze      = 1'b0;
        nxt_st.freeze_pend = 1'b0;
        nxt_st.err_cnt     = 4'h0;
      end
    end

    // sticky flags: a hardware event in the clearing cycle survives
    fl_set = 8'h00;
    fl_set[FL_STALL]      = evt.stall_rcvd;
    fl_set[FL_SETUP_SENT] = evt.setup_sent;
    fl_set[FL_PIPE_ERR]   = evt.pipe_err;
    fl_set[FL_XFER_FAIL]  = evt.xfer_fail;
    fl_set[FL_XFER_DONE]  = evt.xfer_done | evt.lpm_done | en_rise;
    nxt_st.flags  = (st_ff.flags & ~fl_clr) | fl_set;
    nxt_st.irq_en = (st_ff.irq_en & ~ie_clr) | (ie_set & ~ie_clr);
    nxt_st.bank_st[BK_FLOW_ERR] = (st_ff.bank_st[BK_FLOW_ERR] & ~bk_clr[BK_FLOW_ERR])
                                | evt.nak_rcvd | evt.iso_overrun | evt.iso_underflow;
    nxt_st.bank_st[BK_CRC_ERR]  = (st_ff.bank_st[BK_CRC_ERR] & ~bk_clr[BK_CRC_ERR])
                                | evt.crc_err;

    // soft reset restores power-on state but still completes the bus cycle
    if (wr && idx == IDX_CONFIG && avs_writedata[CFG_SOFT_RESET]) begin
      nxt_st     = ST_RESET;
      nxt_st.ack = req & ~st_ff.ack;
    end
  end

  // single state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      st_ff <= ST_RESET;
    else
      st_ff <= nxt_st;
  end

  // engine controls straight from flops
  always_comb begin
    ctl.stall_handshake = ~st_ff.host_mode & st_ff.status[ST_STALL_REQ];
    ctl.current_bank    = st_ff.status[ST_CUR_BANK];
    ctl.in_toggle       = st_ff.status[ST_IN_TOGGLE];
    ctl.out_toggle      = st_ff.status[ST_OUT_TOGGLE];
    ctl.pipe_toggle     = st_ff.pipe_tgl;
    ctl.pipe_frozen     = st_ff.freeze;
    ctl.req_allowed     = st_ff.host_mode & st_ff.pipe_en & ~st_ff.freeze & ~st_ff.freeze_pend;
    ctl.endpoint_num    = st_ff.pctrl[PC_EPNUM_LSB +: 4];
    ctl.device_addr     = st_ff.pctrl[6:0];
    ctl.irq_request     = |(st_ff.flags & st_ff.irq_en);
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_bus_wait_one: assert property ((req && !st_ff.ack) |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
    else $error("waitrequest not released after one wait cycle");
  a_stall_answer: assert property ((!st_ff.host_mode && st_ff.status[ST_STALL_REQ]) |-> ctl.stall_handshake)
    else $error("stall request without stall handshake");
  a_setup_clears: assert property ((!st_ff.host_mode && evt.setup_rcvd && st_set[ST_STALL_REQ] == 1'b0)
                                   |=> !st_ff.status[ST_STALL_REQ])
    else $error("setup did not clear stall request");
  a_freeze_waits: assert property ((st_ff.host_mode && !st_ff.freeze && evt.trans_active) |=> !st_ff.freeze)
    else $error("freeze visible during active transaction");
  a_frozen_quiet: assert property ((st_ff.freeze || st_ff.freeze_pend) |-> !ctl.req_allowed)
    else $error("request allowed on frozen pipe");
  a_toggle_flips: assert property ((st_ff.host_mode && evt.trans_done && st_set == 8'h00 && st_clr == 8'h00)
                                   |=> ctl.pipe_toggle != $past(ctl.pipe_toggle))
    else $error("pipe toggle did not flip");
  a_stall_flag: assert property ((evt.stall_rcvd && !rst) |=> (st_ff.flags[FL_STALL] || $past(wr)))
    else $error("stall flag not set");
  a_stall_w1c: assert property ((wr && idx == IDX_INT_FLAGS && avs_writedata[FL_STALL] && !evt.stall_rcvd
                                 && !avs_writedata[CFG_SOFT_RESET]) |=> !st_ff.flags[FL_STALL])
    else $error("stall flag not cleared by one");
  a_irq_gated: assert property ($rose(ctl.irq_request) |-> |(st_ff.flags & st_ff.irq_en))
    else $error("interrupt raised without enabled flag");
  a_flow_error: assert property ((evt.nak_rcvd && !wr) |=> st_ff.bank_st[BK_FLOW_ERR])
    else $error("flow error not recorded");
  a_crc_error: assert property ((evt.crc_err && !wr) |=> st_ff.bank_st[BK_CRC_ERR])
    else $error("checksum error not recorded");
  a_limit_freeze: assert property ((st_ff.host_mode && evt.pipe_err && limit != 4'h0 && cnt_inc == limit && !wr)
                                   |=> (st_ff.freeze || st_ff.freeze_pend))
    else $error("error limit did not freeze pipe");
  a_rsvd_zero: assert property ((avs_read && !avs_waitrequest && idx == IDX_INT_FLAGS)
                                |-> (avs_readdata & ~{24'h0, FL_MASK}) == 32'h0)
    else $error("reserved flag bits read nonzero");

  c_stall_setup: cover property (ctl.stall_handshake ##[1:20] !ctl.stall_handshake);
  c_freeze_land: cover property (st_ff.freeze_pend && evt.trans_active ##[1:20] st_ff.freeze);
  c_limit_hit:   cover property (st_ff.host_mode && evt.pipe_err && cnt_inc == limit && limit != 4'h0);
  c_irq_raise:   cover property ($rose(ctl.irq_request));

endmodule // usb_ep_status

/* File: test/usb_engine_model.sv */
// usb_engine_model: behavioural packet engine facing the status block.
// assumes core_clk of the block; pulses and levels change just after an edge.
`timescale 1ns/1ps
module usb_engine_model
  import usb_ep_pkg::*;
(
  input  wire logic     core_clk,
  input  wire usb_ctl_s ctl,
  output usb_evt_s      evt
);
  initial evt = '0;

  // one-cycle event pulse; never overlaps a running transaction
  task automatic fire(input usb_evt_s e);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= '0;
    @(negedge core_clk);
  endtask

  // bus transaction, only started while the block allows requests
  task automatic xact(input int len, output bit started);
    int n;
    started = 1'b0;
    for (n = 0; n < 4 && !started; n++) begin
      @(posedge core_clk);
      started = (ctl.req_allowed === 1'b1);
    end
    if (started) begin
      evt.trans_active <= 1'b1;
      repeat (len) @(posedge core_clk);
      evt.trans_active <= 1'b0;
      evt.trans_done   <= 1'b1;
      @(posedge core_clk);
      evt.trans_done   <= 1'b0;
      @(negedge core_clk);
    end
  endtask
endmodule // usb_engine_model

/* File: test/usb_ep_status_tb.sv */
// usb_ep_status_tb: self-checking bench, integer model of the register state.
// assumes usb_engine_model drives evt; avalon master lives in this module.
`timescale 1ns/1ps
module usb_ep_status_tb
  import usb_ep_pkg::*;
;
  logic        core_clk       = 1'b0;
  logic        rst            = 1'b1;
  logic [11:0] avs_address    = '0;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = '0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] rd;
  usb_evt_s    evt;
  usb_ctl_s    ctl;
  usb_evt_s    e;
  bit          ok;
  int          n_mismatch = 0;
  int          checks     = 0;
  int          host = 0, st = 0, fl = 0, ien = 0, bk = 0, pc = 0;

  always #2.5 core_clk = ~core_clk;

  usb_ep_status dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt(evt), .ctl(ctl));
  usb_engine_model eng (.core_clk(core_clk), .ctl(ctl), .evt(evt));

  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon access: held until waitrequest is seen low at a rising edge
  task automatic bus(input bit wr, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    avs_address   <= {idx, 2'b00};
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wd;
    n = 0;
    // waitrequest and readdata are read at the rising edge, before the flops move
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // let the answering edge settle before callers look at ctl
    @(negedge core_clk);
    if (n >= 20) begin
      n_mismatch++;
      close_out();
    end
  endtask

  // write, then mirror its effect in the integer model
  task automatic wr(input logic [9:0] idx, input int d);
    bus(1'b1, idx, d, rd);
    case (idx)
      IDX_STATUS_SET: st |= d & (host ? 'h15 : 'h57);
      IDX_STATUS_CLR: st &= ~d;
      IDX_IRQEN_SET:  ien |= d & 'h3D;
      IDX_IRQEN_CLR:  ien &= ~d;
      IDX_INT_FLAGS:  fl &= ~d;
      IDX_BANK_STAT:  bk &= ~d;
      IDX_PIPE_CTRL:  pc = d & 'hFF7F;
      default: ;
    endcase
  endtask

  task automatic rc(input logic [9:0] idx, input int exp);
    bus(1'b0, idx, '0, rd);
    check(rd, exp);
  endtask

  task automatic ev(input usb_evt_s x);
    eng.fire(x);
  endtask

  initial begin
    ok = $urandom(55656);
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rc(IDX_INT_FLAGS, 0);
    rc(IDX_PIPE_CTRL, 0);
    rc(IDX_STATUS, 0);
    rc(10'h3FF, 0);
    $display("test reset done");
    // device mode: bank, stall, bank select, toggles
    e = '0; e.bank_filled = 1'b1; ev(e); st |= 'h40;
    rc(IDX_STATUS, st);
    wr(IDX_STATUS_SET, 'hBE);
    check(ctl.stall_handshake, 1);
    check(ctl.current_bank, 1);
    rc(IDX_STATUS_CLR, st);
    e = '0; e.in_done = 1'b1; e.out_done = 1'b1; ev(e); st ^= 'h03;
    check(ctl.in_toggle, st[1]);
    check(ctl.out_toggle, st[0]);
    e = '0; e.setup_rcvd = 1'b1; ev(e); st &= ~'h10;
    check(ctl.stall_handshake, 0);
    wr(IDX_STATUS_CLR, 'h57);
    rc(IDX_STATUS_SET, st);
    $display("test device done");
    // host mode: flags, interrupt gating, bank status
    host = 1; wr(IDX_CONFIG, 'h03); fl |= 'h01;
    rc(IDX_INT_FLAGS, fl);
    e = '0; e.stall_rcvd = 1'b1; e.pipe_err = 1'b1; ev(e); fl |= 'h28;
    rc(IDX_INT_FLAGS, fl);
    check(ctl.irq_request, 0);
    wr(IDX_IRQEN_SET, 'h20);
    check(ctl.irq_request, 1);
    wr(IDX_INT_FLAGS, 'h00);
    rc(IDX_INT_FLAGS, fl);
    wr(IDX_INT_FLAGS, 'h29);
    check(ctl.irq_request, 0);
    e = '0; e.lpm_done = 1'b1; e.setup_sent = 1'b1; e.xfer_fail = 1'b1; ev(e); fl |= 'h15;
    rc(IDX_INT_FLAGS, fl);
    e = '0; e.nak_rcvd = 1'b1; e.crc_err = 1'b1; ev(e); bk = 3;
    rc(IDX_BANK_STAT, bk);
    wr(IDX_BANK_STAT, 'h02); e = '0; e.iso_underflow = 1'b1; ev(e); bk |= 2;
    rc(IDX_BANK_STAT, bk);
    wr(IDX_PIPE_CTRL, $urandom & 'h0FFF);
    rc(IDX_PIPE_CTRL, pc);
    check(ctl.endpoint_num, pc[11:8]);
    check(ctl.device_addr, pc[6:0]);
    $display("test host regs done");
    // toggle, freeze mid-transaction, error limit
    eng.xact(3, ok); st ^= 1;
    check(ctl.pipe_toggle, st[0]);
    fork
      eng.xact(14, ok);
      begin
        repeat (2) @(posedge core_clk);
        wr(IDX_STATUS_SET, 'h10);
        rc(IDX_STATUS, st & ~'h10);
      end
    join
    st ^= 1;
    rc(IDX_STATUS, st);
    eng.xact(3, ok);
    check(ok, 0);
    wr(IDX_STATUS_CLR, 'h10);
    check(ctl.req_allowed, 1);
    wr(IDX_PIPE_CTRL, pc | 'h2000);
    e = '0; e.pipe_err = 1'b1; ev(e);
    check(ctl.pipe_frozen, 0);
    ev(e); st |= 'h10;
    check(ctl.pipe_frozen, 1);
    $display("test freeze done");
    wr(IDX_CONFIG, 'h80);
    rc(IDX_STATUS, 0);
    rc(IDX_INT_FLAGS, 0);
    rc(IDX_PIPE_CTRL, 0);
    rc(IDX_BANK_STAT, 0);
    $display("test soft reset done");
    close_out();
  end
endmodule // usb_ep_status_tb
